// file: src/sys_clock_power_mode_ctrl.sv
// system clock select, fast oscillator control and stop-instruction power modes
// assumes oscillator ticks and cpu strobes are one-cycle pulses synchronous to pclk
`timescale 1ns/100ps
`default_nettype none
`include "clk_pwr_params.svh"
module sys_clock_power_mode_ctrl #(
    parameter int unsigned STAB_CYCLES = `STAB_CYC
) (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic [31:0]              prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic                hs_tick,
    input  wire logic                ls_tick,
    input  wire logic                ls_stable,
    input  wire logic                stop_instr,
    input  wire logic                wake,
    input  wire logic                wdt_enabled,
    input  wire logic                wdt_overflow,
    input  wire logic                clr_wdt_instr,
    output logic                     sys_tick,
    output logic                     hs_osc_run,
    output logic [1:0]               hs_freq,
    output logic                     ls_osc_run,
    output logic                     sub_clk_run,
    output logic                     cpu_halted,
    output clk_pwr_pkg::sys_mode_t   sys_mode,
    output logic                     power_down_flag,
    output logic                     wdt_timeout_flag,
    output logic                     wdt_clear
);
    import clk_pwr_pkg::*;

    osc_ctl_if osc ();

    logic [2:0]  sel_q, sel_d;
    logic        hs_idle_q, hs_idle_d;
    logic        ls_idle_q, ls_idle_d;
    logic [1:0]  freq_q, freq_d;
    logic        en_q, en_d;
    logic [31:0] prdata_q, prdata_d;
    logic        pready_q, pready_d;
    logic        pslverr_q, pslverr_d;
    logic [2:0]  cur_q, cur_d;
    sw_state_t   sw_q, sw_d;
    logic [2:0]  swcnt_q, swcnt_d;
    logic [5:0]  div_q, div_d;
    logic        halted_q, halted_d;
    logic        pdn_q, pdn_d;
    logic        to_q, to_d;
    logic        wclr_q, wclr_d;
    logic        tick_q, tick_d;
    logic        hsrun_q, hsrun_d;
    logic        lsrun_q, lsrun_d;
    logic        subrun_q, subrun_d;
    sys_mode_t   mode_q, mode_d;
    logic        access, wr_en, mapped;
    logic        cur_tick, tgt_tick, tgt_ready;

    // tick of a clock source code from the fast divider or the slow clock
    // the divider counts fast ticks; code n fires when its low n bits are all ones,
    // so every divided clock shares one phase and a switch never sees a half period
    function automatic logic src_tick(input logic [2:0] code, input logic [5:0] div,
                                      input logic hs, input logic ls);
        logic [5:0] mask;
        mask = 6'(6'h3F >> (3'h6 - code));
        if (code == `SEL_SLOW) begin
            src_tick = ls;
        end else begin
            src_tick = hs && ((div & mask) == mask);
        end
    endfunction : src_tick

    // stability tracker of the fast oscillator
    hs_osc_stabilizer #(
        .STAB_CYCLES (STAB_CYCLES)
    ) u_stab (
        .pclk    (pclk),
        .presetn (presetn),
        .osc     (osc)
    );

    // controller side of the oscillator carrier
    assign osc.en       = en_q;
    assign osc.freq_req = freq_q;

    // apb decode; one wait state, writes blocked while the cpu is stopped
    // pready stays low on the first access cycle so every transfer costs one
    // wait state; a halted cpu cannot write, which freezes the registers
    always_comb begin
        access = psel && penable;
        mapped = (paddr == `SEL_OFS) || (paddr == `HOC_OFS) || (paddr == `STAT_OFS);
        wr_en  = access && pready_q && pwrite && mapped && !halted_q;
    end

    // register file next values and read data
    // reserved bits and unmapped addresses read as zero, so software sees
    // stable values whatever the decode does
    always_comb begin
        sel_d     = sel_q;
        hs_idle_d = hs_idle_q;
        ls_idle_d = ls_idle_q;
        freq_d    = freq_q;
        en_d      = en_q;
        prdata_d  = prdata_q;
        pready_d  = access && !pready_q;
        pslverr_d = access && !pready_q && !mapped;
        if (wr_en && paddr == `SEL_OFS) begin
            sel_d     = pwdata[`SEL_LSB +: 3];
            hs_idle_d = pwdata[`HS_IDLE_BIT];
            ls_idle_d = pwdata[`LS_IDLE_BIT];
        end
        if (wr_en && paddr == `HOC_OFS) begin
            freq_d = pwdata[`FREQ_LSB +: 2];
            en_d   = pwdata[`EN_BIT];
        end
        if (access && !pready_q) begin
            prdata_d = 32'h0000_0000;
            case (paddr)
                `SEL_OFS: begin
                    prdata_d[`SEL_LSB +: 3]   = sel_q;
                    prdata_d[`HS_IDLE_BIT]    = hs_idle_q;
                    prdata_d[`LS_IDLE_BIT]    = ls_idle_q;
                end
                `HOC_OFS: begin
                    prdata_d[`FREQ_LSB +: 2]  = freq_q;
                    prdata_d[`STAB_BIT]       = osc.stable;
                    prdata_d[`EN_BIT]         = en_q;
                end
                `STAT_OFS: begin
                    prdata_d[`STAT_PDN_BIT]       = pdn_q;
                    prdata_d[`STAT_TMO_BIT]       = to_q;
                    prdata_d[`STAT_HALT_BIT]      = halted_q;
                    prdata_d[`STAT_BUSY_BIT]      = (sw_q != sw_idle);
                    prdata_d[`STAT_SRC_LSB +: 3]  = cur_q;
                    prdata_d[`STAT_MODE_LSB +: 3] = mode_q;
                end
                default: prdata_d = 32'h0000_0000;
            endcase
        end
    end

    // source switch: four current ticks, then the first ready target tick
    // the old source keeps ticking for four periods, then ticks are held back
    // until the new source is ready and on its own edge; a late or missing
    // target never produces a short system clock pulse
    always_comb begin
        div_d     = hs_tick ? div_q + 6'h01 : div_q;
        cur_tick  = src_tick(cur_q, div_q, hs_tick, ls_tick);
        tgt_tick  = src_tick(sel_q, div_q, hs_tick, ls_tick);
        tgt_ready = (sel_q == `SEL_SLOW) ? ls_stable : osc.stable;
        cur_d     = cur_q;
        sw_d      = sw_q;
        swcnt_d   = swcnt_q;
        tick_d    = cur_tick;
        case (sw_q)
            sw_idle: begin
                if (sel_q != cur_q) begin
                    sw_d    = sw_count;
                    swcnt_d = 3'h0;
                end
            end
            sw_count: begin
                if (cur_tick) begin
                    swcnt_d = swcnt_q + 3'h1;
                    if (swcnt_q == `SWITCH_TICKS - 3'h1) begin
                        sw_d = sw_wait;
                    end
                end
            end
            sw_wait: begin
                if (sel_q == cur_q) begin
                    sw_d = sw_idle;
                end else if (tgt_tick && tgt_ready) begin
                    cur_d  = sel_q;
                    tick_d = 1'b1;
                    sw_d   = sw_idle;
                end else begin
                    tick_d = 1'b0;
                end
            end
            default: sw_d = sw_idle;
        endcase
        if (halted_q && !((cur_q == `SEL_SLOW) ? ls_idle_q : hs_idle_q)) begin
            tick_d = 1'b0;
        end
    end

    // stop instruction, wake, flags and oscillator gating
    // stop beats the watchdog clear and the overflow in the same cycle, so the
    // power-down flag and the cleared timeout always reflect the last stop
    always_comb begin
        halted_d = halted_q;
        pdn_d    = pdn_q;
        to_d     = to_q;
        wclr_d   = 1'b0;
        if (clr_wdt_instr) begin
            pdn_d = 1'b0;
        end
        if (wdt_overflow) begin
            to_d = 1'b1;
        end
        if (wake) begin
            halted_d = 1'b0;
        end
        if (stop_instr && !halted_q) begin
            halted_d = 1'b1;
            pdn_d    = 1'b1;
            to_d     = 1'b0;
            wclr_d   = 1'b1;
        end
        hsrun_d  = en_q && !(halted_q && !hs_idle_q);
        lsrun_d  = !halted_q || ls_idle_q || wdt_enabled;
        subrun_d = !halted_q || ls_idle_q;
        if (!halted_q) begin
            mode_d = (cur_q == `SEL_SLOW) ? mode_slow : mode_fast;
        end else begin
            case ({hs_idle_q, ls_idle_q})
                2'b01:   mode_d = idle_slow_clock_only;
                2'b11:   mode_d = idle_both_clocks;
                2'b10:   mode_d = idle_fast_clock_only;
                default: mode_d = mode_sleep;
            endcase
        end
    end

    // register everything; outputs except hs_freq come straight from these flops
    // one asynchronous reset for all state; only constants are loaded here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_q     <= `SEL_RST;
            hs_idle_q <= `IDLE_RST;
            ls_idle_q <= `IDLE_RST;
            freq_q    <= `FREQ_RST;
            en_q      <= `EN_RST;
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            cur_q     <= `SEL_RST;
            sw_q      <= sw_idle;
            swcnt_q   <= 3'h0;
            div_q     <= 6'h00;
            halted_q  <= 1'b0;
            pdn_q     <= 1'b0;
            to_q      <= 1'b0;
            wclr_q    <= 1'b0;
            tick_q    <= 1'b0;
            hsrun_q   <= 1'b0;
            lsrun_q   <= 1'b0;
            subrun_q  <= 1'b0;
            mode_q    <= mode_fast;
        end else begin
            sel_q     <= sel_d;
            hs_idle_q <= hs_idle_d;
            ls_idle_q <= ls_idle_d;
            freq_q    <= freq_d;
            en_q      <= en_d;
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
            cur_q     <= cur_d;
            sw_q      <= sw_d;
            swcnt_q   <= swcnt_d;
            div_q     <= div_d;
            halted_q  <= halted_d;
            pdn_q     <= pdn_d;
            to_q      <= to_d;
            wclr_q    <= wclr_d;
            tick_q    <= tick_d;
            hsrun_q   <= hsrun_d;
            lsrun_q   <= lsrun_d;
            subrun_q  <= subrun_d;
            mode_q    <= mode_d;
        end
    end

    // freq applied is a register inside the tracker
    // the tracker owns this register, so no extra delay sits on the applied code
    always_comb begin
        hs_freq = osc.freq_applied;
    end

    // ports are driven straight from the registers above
    assign prdata           = prdata_q;
    assign pready           = pready_q;
    assign pslverr          = pslverr_q;
    assign sys_tick         = tick_q;
    assign hs_osc_run       = hsrun_q;
    assign ls_osc_run       = lsrun_q;
    assign sub_clk_run      = subrun_q;
    assign cpu_halted       = halted_q;
    assign sys_mode         = mode_q;
    assign power_down_flag  = pdn_q;
    assign wdt_timeout_flag = to_q;
    assign wdt_clear        = wclr_q;
endmodule : sys_clock_power_mode_ctrl
`default_nettype wire

// file: src/clk_pwr_params.svh
// constants of the system clock and power-mode controller
// assumes an apb slave with 8-bit byte addresses and 32-bit data
// Overview of operation
// - sys_clk_sel picks fast, fast/2..64 or slow
// - unimplemented register bits read as zero
// - hs_osc_idle_en keeps fast oscillator during stop
// - ls_osc_idle_en keeps slow oscillator during stop
// - source change finishes within bounded switching delay; the code waits without limit after four old ticks until the target is ready
// - hs_osc_freq_sel 01=16MHz, 10=20MHz, others reserved
// - new fast frequency applied after stable flag
// - stable flag read-only, cleared then set
// - hs_osc_en runs fast oscillator, resets to one
// - idle enables choose the low-power mode
// - slow switch completes after slow oscillator stable
// - sleep stops all clocks, execution halts; the slow oscillator keeps running while wdt_enabled is set
// - low-power entry keeps registers and state
// - stop sets power_down_flag, clears wdt_timeout_flag
// - stop clears the watchdog counter
`ifndef CLK_PWR_PARAMS_SVH
`define CLK_PWR_PARAMS_SVH
`define SEL_OFS       8'h00
`define HOC_OFS       8'h04
`define STAT_OFS      8'h08
`define SEL_LSB       5
`define HS_IDLE_BIT   1
`define LS_IDLE_BIT   0
`define FREQ_LSB      2
`define STAB_BIT      1
`define EN_BIT        0
`define STAT_PDN_BIT  0
`define STAT_TMO_BIT  1
`define STAT_HALT_BIT 2
`define STAT_BUSY_BIT 3
`define STAT_SRC_LSB  4
`define STAT_MODE_LSB 8
`define SEL_RST       3'h2
`define FREQ_RST      2'h0
`define FREQ_APP_RST  2'h1
`define EN_RST        1'h1
`define IDLE_RST      1'h0
`define SEL_SLOW      3'h7
`define FREQ_16M      2'h1
`define FREQ_20M      2'h2
`define SWITCH_TICKS  3'h4
`define STAB_CYC      1024
`endif

// file: src/clk_pwr_pkg.sv
// types shared by the clock and power-mode controller files
// assumes the constants header is included by the modules
package clk_pwr_pkg;
    typedef enum logic [2:0] {
        mode_fast, mode_slow, mode_sleep,
        idle_slow_clock_only, idle_both_clocks, idle_fast_clock_only
    } sys_mode_t;
    typedef enum logic [1:0] {sw_idle, sw_count, sw_wait} sw_state_t;
endpackage : clk_pwr_pkg

// file: src/osc_ctl_if.sv
// carrier between the controller and the fast oscillator stability tracker
// assumes both ends run on pclk
`timescale 1ns/100ps
`default_nettype none
interface osc_ctl_if;
    logic       en;
    logic [1:0] freq_req;
    logic       stable;
    logic [1:0] freq_applied;
    modport ctrl (output en, output freq_req, input stable, input freq_applied);
    modport stab (input en, input freq_req, output stable, output freq_applied);
endinterface : osc_ctl_if
`default_nettype wire

// file: src/hs_osc_stabilizer.sv
// tracks fast oscillator start-up and applies frequency once stable
// assumes the oscillator settles within STAB_CYCLES pclk cycles
`timescale 1ns/100ps
`default_nettype none
`include "clk_pwr_params.svh"
module hs_osc_stabilizer #(
    parameter int unsigned STAB_CYCLES = `STAB_CYC
) (
    input  wire logic  pclk,
    input  wire logic  presetn,
    osc_ctl_if.stab    osc
);
    logic [15:0] cnt_q, cnt_d;
    logic        stable_q, stable_d;
    logic [1:0]  app_q, app_d;
    logic [1:0]  seen_q, seen_d;
    logic        en_seen_q, en_seen_d;

    // restart on enable or frequency change, then count to stable
    always_comb begin
        cnt_d     = cnt_q;
        stable_d  = stable_q;
        app_d     = app_q;
        seen_d    = osc.freq_req;
        en_seen_d = osc.en;
        if (!osc.en) begin
            cnt_d    = 16'h0000;
            stable_d = 1'b0;
        end else if (!en_seen_q || osc.freq_req != seen_q) begin
            cnt_d    = 16'h0000;
            stable_d = 1'b0;
        end else if (!stable_q) begin
            cnt_d = cnt_q + 16'h0001;
            if (cnt_q == 16'(STAB_CYCLES - 1)) begin
                stable_d = 1'b1;
                if (osc.freq_req == `FREQ_16M || osc.freq_req == `FREQ_20M) begin
                    app_d = osc.freq_req;
                end
            end
        end
    end

    // register the tracker state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q     <= 16'h0000;
            stable_q  <= 1'b0;
            app_q     <= `FREQ_APP_RST;
            seen_q    <= `FREQ_RST;
            en_seen_q <= 1'b0;
        end else begin
            cnt_q     <= cnt_d;
            stable_q  <= stable_d;
            app_q     <= app_d;
            seen_q    <= seen_d;
            en_seen_q <= en_seen_d;
        end
    end

    assign osc.stable       = stable_q;
    assign osc.freq_applied = app_q;
endmodule : hs_osc_stabilizer
`default_nettype wire

// file: testbench/osc_model.sv
// oscillator partner model: fast and slow tick pulses and slow stability
// assumes pclk runs faster than both oscillators; ticks stand one cycle
`timescale 1ns/100ps
`default_nettype none
module osc_model (
    input  wire logic clk,
    input  wire logic rstn,
    output logic      hs_tick,
    output logic      ls_tick,
    output logic      ls_stable
);
    logic [4:0] cnt_q;
    // free-running phase counter; slow side reports stable only after start-up
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q     <= 5'h00;
            ls_stable <= 1'b0;
        end else begin
            cnt_q <= cnt_q + 5'h01;
            if (&cnt_q) ls_stable <= 1'b1;
        end
    end
    // fast tick every 2 cycles, slow tick every 32 cycles
    assign hs_tick = cnt_q[0];
    assign ls_tick = &cnt_q;
endmodule : osc_model
`default_nettype wire

// file: testbench/clk_pwr_sva.sv
// checker for the clock and power-mode controller
// assumes it is bound to the controller and sees its ports only
`timescale 1ns/100ps
`default_nettype none
module clk_pwr_sva
    import clk_pwr_pkg::*;
(
    input wire logic                 pclk,
    input wire logic                 presetn,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [7:0]           paddr,
    input wire logic [31:0]          prdata,
    input wire logic                 pready,
    input wire logic                 pslverr,
    input wire logic                 stop_instr,
    input wire logic                 sys_tick,
    input wire logic                 hs_osc_run,
    input wire logic                 sub_clk_run,
    input wire logic                 cpu_halted,
    input wire clk_pwr_pkg::sys_mode_t sys_mode,
    input wire logic                 power_down_flag,
    input wire logic                 wdt_timeout_flag,
    input wire logic                 wdt_clear
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // bus answer timing
    property p_ready;
        psel && penable && !pready |=> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("access not answered");
    property p_err;
        pslverr |-> pready;
    endproperty
    a_err: assert property (p_err) else $error("error without ready");
    // unimplemented bits read zero
    property p_scc_zero;
        pready && !pwrite && paddr == 8'h00 |-> prdata[4:2] == 3'h0 && prdata[31:8] == 24'h0;
    endproperty
    a_scc_zero: assert property (p_scc_zero) else $error("select reserved bits set");
    property p_hoc_zero;
        pready && !pwrite && paddr == 8'h04 |-> prdata[31:4] == 28'h0;
    endproperty
    a_hoc_zero: assert property (p_hoc_zero) else $error("osc reserved bits set");
    // stop instruction effects
    property p_stop_flags;
        stop_instr && !cpu_halted |=> power_down_flag && !wdt_timeout_flag && cpu_halted;
    endproperty
    a_stop_flags: assert property (p_stop_flags) else $error("stop flags wrong");
    property p_stop_wdt;
        stop_instr && !cpu_halted |=> wdt_clear ##1 !wdt_clear;
    endproperty
    a_stop_wdt: assert property (p_stop_wdt) else $error("watchdog clear pulse wrong");
    // clock gates per low-power mode
    property p_sleep;
        sys_mode == mode_sleep |-> !hs_osc_run && !sub_clk_run;
    endproperty
    a_sleep: assert property (p_sleep) else $error("clock running in sleep");
    property p_sleep_tick;
        sys_mode == mode_sleep [*2] |-> !sys_tick;
    endproperty
    a_sleep_tick: assert property (p_sleep_tick) else $error("system tick in sleep");
    property p_idle_both;
        sys_mode == idle_both_clocks |-> hs_osc_run && sub_clk_run;
    endproperty
    a_idle_both: assert property (p_idle_both) else $error("both-clock idle gate");
    property p_idle_fast;
        sys_mode == idle_fast_clock_only |-> hs_osc_run && !sub_clk_run;
    endproperty
    a_idle_fast: assert property (p_idle_fast) else $error("fast-only idle gate");
    property p_idle_slow;
        sys_mode == idle_slow_clock_only |-> !hs_osc_run && sub_clk_run;
    endproperty
    a_idle_slow: assert property (p_idle_slow) else $error("slow-only idle gate");
endmodule : clk_pwr_sva
bind sys_clock_power_mode_ctrl clk_pwr_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .prdata, .pready, .pslverr, .stop_instr, .sys_tick, .hs_osc_run, .sub_clk_run,
    .cpu_halted, .sys_mode, .power_down_flag, .wdt_timeout_flag, .wdt_clear);
`default_nettype wire

// file: testbench/sys_clock_power_mode_ctrl_tb.sv
// self-checking bench for the clock and power-mode controller
// assumes oscillator ticks from the partner model and a 20 MHz pclk
`timescale 1ns/100ps
`default_nettype none
module sys_clock_power_mode_ctrl_tb;
    import clk_pwr_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err, hs_tick, ls_tick, ls_stable, sys_tick, hs_osc_run;
    logic        ls_osc_run, sub_clk_run, cpu_halted, power_down_flag, wdt_timeout_flag;
    logic        wdt_clear;
    logic [3:0]  ev = 4'h0; // stop, wake, overflow, clear-watchdog pulses
    logic        wdt_en = 1'b0;
    logic [1:0]  hs_freq;
    sys_mode_t   sys_mode;
    int          bad_count = 0;
    int          total_checks = 0;
    int          n;
    sys_mode_t   exp_mode [4] = '{mode_sleep, idle_slow_clock_only, idle_fast_clock_only,
                                  idle_both_clocks};
    always #25 pclk = ~pclk;
    osc_model u_osc (.clk(pclk), .rstn(presetn), .hs_tick, .ls_tick, .ls_stable);
    sys_clock_power_mode_ctrl #(.STAB_CYCLES(8)) u_dut (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .hs_tick, .ls_tick, .ls_stable,
        .stop_instr(ev[0]), .wake(ev[1]), .wdt_enabled(wdt_en), .wdt_overflow(ev[2]),
        .clr_wdt_instr(ev[3]), .sys_tick, .hs_osc_run, .hs_freq, .ls_osc_run, .sub_clk_run,
        .cpu_halted, .sys_mode, .power_down_flag, .wdt_timeout_flag, .wdt_clear);
    // one bus transfer; held until ready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic pulse(input int b);
        @(posedge pclk);
        ev[b] <= 1'b1;
        @(posedge pclk);
        ev[b] <= 1'b0;
    endtask : pulse
    // read until masked value appears, bounded
    task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
        for (int i = 0; i < 200; i++) begin
            apb(1'b0, a, 32'h0);
            if ((rd & m) === v) break;
        end
    endtask : poll
    // cycles between two system ticks
    task automatic period(output int c);
        c = 0;
        do @(posedge pclk); while (sys_tick !== 1'b1);
        do begin
            @(posedge pclk);
            c++;
        end while (sys_tick !== 1'b1 && c < 300);
    endtask : period
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : finish_test
    initial begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        finish_test;
    end
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        chk("osc_run", 32'h1, hs_osc_run);
        apb(1'b0, 8'h00, 32'h0); chk("scc_rst", 32'h40, rd);
        poll(8'h04, 32'h2, 32'h2); chk("hoc_rst", 32'h3, rd);
        $display("test reset done");
        apb(1'b1, 8'h00, 32'hFFFFFFFF); apb(1'b0, 8'h00, 32'h0); chk("scc_rw", 32'hE3, rd);
        apb(1'b1, 8'h04, 32'hFFFFFFFF); apb(1'b0, 8'h04, 32'h0); chk("hoc_rw", 32'hD, rd);
        poll(8'h04, 32'h2, 32'h2); chk("freq_keep", 32'h1, hs_freq);
        apb(1'b1, 8'h04, 32'h9); apb(1'b0, 8'h04, 32'h0); chk("flag_clr", 32'h9, rd);
        chk("freq_wait", 32'h1, hs_freq);
        poll(8'h04, 32'h2, 32'h2); repeat (2) @(posedge pclk); chk("freq_20", 32'h2, hs_freq);
        apb(1'b1, 8'h04, 32'h8); repeat (2) @(posedge pclk); chk("osc_off", 32'h0, hs_osc_run);
        apb(1'b1, 8'h04, 32'h9); poll(8'h04, 32'h2, 32'h2); chk("osc_on", 32'h1, hs_osc_run);
        apb(1'b0, 8'h0C, 32'h0); chk("unmapped", 32'h1, err);
        chk("unmapped_rd", 32'h0, rd);
        $display("test registers done");
        apb(1'b1, 8'h00, 32'hE0); poll(8'h08, 32'h778, 32'h170);
        chk("to_slow", 32'h170, rd & 32'h778);
        period(n); chk("slow_period", 32'd32, n);
        for (int c = 0; c < 7; c++) begin
            apb(1'b1, 8'h00, 32'(c) << 5);
            poll(8'h08, 32'h78, 32'(c) << 4);
            period(n); chk("div_period", 32'd2 << c, n);
        end
        $display("test clock switch done");
        for (int m = 0; m < 5; m++) begin
            int k;
            k = m % 4;
            wdt_en <= (m == 4); // last pass repeats sleep with the watchdog running
            apb(1'b1, 8'h00, 32'(k));
            pulse(2);
            pulse(0);
            repeat (3) @(posedge pclk);
            chk("mode", exp_mode[k], sys_mode);
            chk("fast_osc", k[1], hs_osc_run);
            chk("sub_clk", k[0], sub_clk_run);
            chk("slow_osc", k[0] | (m == 4), ls_osc_run);
            chk("pwr_dn", 32'h1, power_down_flag); chk("tof", 32'h0, wdt_timeout_flag);
            apb(1'b1, 8'h00, 32'hE0); apb(1'b0, 8'h00, 32'h0); chk("held", 32'(k), rd);
            pulse(1);
            repeat (3) @(posedge pclk);
            chk("awake", 32'h0, cpu_halted);
        end
        pulse(3); repeat (2) @(posedge pclk); chk("pwr_dn_clr", 32'h0, power_down_flag);
        $display("test power modes done");
        finish_test;
    end
endmodule : sys_clock_power_mode_ctrl_tb
`default_nettype wire
